// ==== hdl/sow_pkg.sv ====
//==========================================================================
// shared constants, types and decode for the single-operand word datapath
package sow_pkg;

    //======================================================================
    // word and instruction field layout
    localparam int OPC_HI = 15;              // operation code top bit
    localparam int OPC_LO = 6;               // operation code bottom bit
    localparam int DST_HI = 5;               // destination specifier top bit
    localparam int DST_LO = 0;               // destination specifier bottom bit

    //======================================================================
    // operation codes, instruction bits 15..6
    localparam logic [9:0] OPC_ZERO   = 10'h028;
    localparam logic [9:0] OPC_INVERT = 10'h029;
    localparam logic [9:0] OPC_ADD1   = 10'h02A;
    localparam logic [9:0] OPC_SUB1   = 10'h02B;
    localparam logic [9:0] OPC_NEGATE = 10'h02C;
    localparam logic [9:0] OPC_ADDC   = 10'h02D;
    localparam logic [9:0] OPC_SUBC   = 10'h02E;
    localparam logic [9:0] OPC_CHECK  = 10'h02F;
    localparam logic [9:0] OPC_ROT_R  = 10'h030;
    localparam logic [9:0] OPC_ROT_L  = 10'h031;
    localparam logic [9:0] OPC_SWAP   = 10'h003;

    //======================================================================
    // special operand values
    localparam logic [15:0] ZERO_W   = 16'h0000;
    localparam logic [15:0] ONE_W    = 16'h0001;
    localparam logic [15:0] MAX_POS  = 16'h7FFF;
    localparam logic [15:0] MSB_ONLY = 16'h8000;
    localparam logic [15:0] ALL_ONES = 16'hFFFF;
    localparam logic [7:0]  ZERO_B   = 8'h00;

    //======================================================================
    // timing: basic instruction time in ns, rounded up to clock cycles
    localparam int BASIC_NS  = 2300;
    localparam int CLK_NS    = 20;
    localparam int BASIC_CYC = (BASIC_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [8:0] BASIC_CNT = 9'(BASIC_CYC);
    localparam logic [8:0] CNT_ZERO  = 9'h000;
    localparam logic [8:0] CNT_ONE   = 9'h001;

    //======================================================================
    // types
    typedef struct packed {
        logic n;                             // negative
        logic z;                             // zero
        logic v;                             // overflow
        logic c;                             // carry
    } sow_cc_t;

    typedef enum logic [3:0] {
        op_zero_dest     = 4'h0,
        op_add_one       = 4'h1,
        op_sub_one       = 4'h2,
        op_twos_negate   = 4'h3,
        op_check_value   = 4'h4,
        op_invert_bits   = 4'h5,
        op_add_carry_in  = 4'h6,
        op_sub_carry_in  = 4'h7,
        op_rotate_right  = 4'h8,
        op_rotate_left   = 4'h9,
        op_byte_exchange = 4'hA,
        op_not_single    = 4'hF
    } sow_op_t;

    typedef enum logic [0:0] {
        st_idle = 1'b0,
        st_run  = 1'b1
    } sow_state_t;

    localparam sow_cc_t CC_RST = 4'h0;       // flags after reset
    localparam logic [15:0] RES_RST = 16'h0000;

    //======================================================================
    // operation code field to operation
    function automatic sow_op_t sow_decode(input logic [9:0] opc);
        case (opc)
            OPC_ZERO:   return op_zero_dest;
            OPC_INVERT: return op_invert_bits;
            OPC_ADD1:   return op_add_one;
            OPC_SUB1:   return op_sub_one;
            OPC_NEGATE: return op_twos_negate;
            OPC_ADDC:   return op_add_carry_in;
            OPC_SUBC:   return op_sub_carry_in;
            OPC_CHECK:  return op_check_value;
            OPC_ROT_R:  return op_rotate_right;
            OPC_ROT_L:  return op_rotate_left;
            OPC_SWAP:   return op_byte_exchange;
            default:    return op_not_single;
        endcase
    endfunction : sow_decode

endpackage : sow_pkg

// ==== hdl/sow_exec.sv ====
`timescale 1ns/100ps
//==========================================================================
// combinational result and flag generation for one operation
module sow_exec (
    input  wire sow_pkg::sow_op_t op,        // decoded operation
    input  wire logic [15:0]      opd,       // destination operand
    input  wire sow_pkg::sow_cc_t cin,       // flags before the operation
    output sow_pkg::sow_cc_t      cc,        // flags after the operation
    output logic [15:0]           res,       // result word
    output logic                  wr         // result is to be written back
);

    // z and n default from the full word; byte swap takes them from the low byte, a stray word keeps them
    always_comb begin
        res = opd;
        wr  = 1'b1;
        cc  = cin;
        case (op)
            sow_pkg::op_zero_dest: begin
                res  = sow_pkg::ZERO_W;
                cc.v = 1'b0;
                cc.c = 1'b0;
            end
            sow_pkg::op_add_one: begin
                res  = 16'(opd + sow_pkg::ONE_W);
                cc.v = (opd == sow_pkg::MAX_POS);
            end
            sow_pkg::op_sub_one: begin
                res  = 16'(opd - sow_pkg::ONE_W);
                cc.v = (opd == sow_pkg::MSB_ONLY);
            end
            sow_pkg::op_twos_negate: begin
                res  = 16'(~opd + sow_pkg::ONE_W);
                cc.c = (res != sow_pkg::ZERO_W);
                cc.v = (res == sow_pkg::MSB_ONLY);
            end
            sow_pkg::op_check_value: begin
                wr   = 1'b0;
                cc.v = 1'b0;
                cc.c = 1'b0;
            end
            sow_pkg::op_invert_bits: begin
                res  = ~opd;
                cc.v = 1'b0;
                cc.c = 1'b1;
            end
            sow_pkg::op_add_carry_in: begin
                res  = 16'(opd + {15'h0000, cin.c});
                cc.c = (opd == sow_pkg::ALL_ONES) && cin.c;
                cc.v = (opd == sow_pkg::MAX_POS) && cin.c;
            end
            sow_pkg::op_sub_carry_in: begin
                res  = 16'(opd - {15'h0000, cin.c});
                cc.c = !((res == sow_pkg::ZERO_W) && cin.c);
                cc.v = (res == sow_pkg::MSB_ONLY);
            end
            sow_pkg::op_rotate_right: begin
                res  = {cin.c, opd[15:1]};
                cc.c = opd[0];
            end
            sow_pkg::op_rotate_left: begin
                res  = {opd[14:0], cin.c};
                cc.c = opd[15];
            end
            sow_pkg::op_byte_exchange: begin
                res  = {opd[7:0], opd[15:8]};
                cc.v = 1'b0;
                cc.c = 1'b0;
            end
            default: begin
                wr = 1'b0;                                    // not ours: no write
            end
        endcase
        // flags from the finished result
        if (op != sow_pkg::op_not_single) begin
            cc.z = (res == sow_pkg::ZERO_W);
            cc.n = res[15];
        end
        if (op == sow_pkg::op_byte_exchange) begin
            cc.z = (res[7:0] == sow_pkg::ZERO_B);
            cc.n = res[7];
        end
        // overflow only after carry and sign settle
        if (op == sow_pkg::op_rotate_right || op == sow_pkg::op_rotate_left) begin
            cc.v = cc.n ^ cc.c;
        end
    end

endmodule : sow_exec

// ==== hdl/sow_alu.sv ====
`timescale 1ns/100ps
//==========================================================================
// Operation
// - clear writes zero, sets Z, clears N, C and V
// - increment adds one; Z,N from result; C kept; V if 077777
// - decrement subtracts one; Z,N from result; C kept; V if 100000
// - negate gives two's complement; C clear only on zero; V if 100000
// - test does not write; Z,N from operand; C and V cleared
// - complement inverts all bits; Z,N from result; C set, V cleared
// - add carry: C if 177777 and carry, V if 077777 and carry
// - subtract carry: C clear only on zero with carry; V if 100000
// - rotate right through carry: bit 0 to C, C to bit 15
// - rotate left through carry: bit 15 to C, C to bit 0
// - rotates: V is new N xor new C
// - byte swap: Z,N from new low byte, C and V cleared
// - operation code in bits 15..6, destination in bits 5..0
// - run time is basic time plus destination address time
module sow_alu (
    input  wire logic             clk,       // 50 MHz system clock
    input  wire logic             rst_n,     // synchronous reset, active low
    input  wire logic             start,     // request pulse, taken when idle
    input  wire logic [15:0]      instr,     // instruction word
    input  wire logic [15:0]      operand,   // destination operand value
    input  wire sow_pkg::sow_cc_t cc_in,     // current condition codes
    input  wire logic [7:0]       dst_cycles,// destination address time
    output logic                  busy,      // operation in progress
    output logic                  done,      // one-cycle completion pulse
    output logic [15:0]           result,    // result word
    output sow_pkg::sow_cc_t      cc_out,    // new condition codes
    output logic                  write_en,  // pulse: write result back
    output logic                  illegal,   // last word was not ours
    output logic [5:0]            dst_spec   // destination specifier
);

    //======================================================================
    // state and captured request
    sow_pkg::sow_state_t state;
    logic [8:0]          cnt;
    sow_pkg::sow_op_t    op_q;
    logic [15:0]         opd_q;
    sow_pkg::sow_cc_t    cin_q;
    sow_pkg::sow_cc_t    ex_cc;
    logic [15:0]         ex_res;
    logic                ex_wr;
    logic                take;
    logic                finish;
    sow_pkg::sow_op_t    next_op;

    assign take    = start && (state == sow_pkg::st_idle);
    assign finish  = (state == sow_pkg::st_run) && (cnt == sow_pkg::CNT_ZERO);
    assign next_op = sow_pkg::sow_decode(instr[sow_pkg::OPC_HI:sow_pkg::OPC_LO]);

    //======================================================================
    // sequencing: basic time plus the address time the partner reports
    // a word that is not ours finishes on the next edge, so a stray
    // decode never stalls the sequencer for the full instruction time
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= sow_pkg::st_idle;
            cnt   <= sow_pkg::CNT_ZERO;
        end else begin
            case (state)
                sow_pkg::st_idle: begin
                    if (start) begin
                        state <= sow_pkg::st_run;
                        if (next_op == sow_pkg::op_not_single) begin
                            cnt <= sow_pkg::CNT_ZERO;
                        end else begin
                            cnt <= 9'(sow_pkg::BASIC_CNT + {1'b0, dst_cycles}
                                      - sow_pkg::CNT_ONE);
                        end
                    end
                end
                sow_pkg::st_run: begin
                    if (cnt == sow_pkg::CNT_ZERO) begin
                        state <= sow_pkg::st_idle;
                    end else begin
                        cnt <= 9'(cnt - sow_pkg::CNT_ONE);
                    end
                end
                default: begin
                    state <= sow_pkg::st_idle;
                end
            endcase
        end
    end

    // busy flag mirrors the run state as a flop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
        end else if (take) begin
            busy <= 1'b1;
        end else if (finish) begin
            busy <= 1'b0;
        end
    end

    //======================================================================
    // request capture; operand is held so the partner may change it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            op_q     <= sow_pkg::op_not_single;
            opd_q    <= sow_pkg::RES_RST;
            cin_q    <= sow_pkg::CC_RST;
            dst_spec <= 6'h00;
        end else if (take) begin
            op_q     <= next_op;
            opd_q    <= operand;
            cin_q    <= cc_in;
            dst_spec <= instr[sow_pkg::DST_HI:sow_pkg::DST_LO];
        end
    end

    //======================================================================
    // datapath
    sow_exec u_exec (
        .op  (op_q),
        .opd (opd_q),
        .cin (cin_q),
        .cc  (ex_cc),
        .res (ex_res),
        .wr  (ex_wr)
    );

    // result and flags load on the same edge, so no stale pairing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result  <= sow_pkg::RES_RST;
            cc_out  <= sow_pkg::CC_RST;
            illegal <= 1'b0;
        end else if (finish) begin
            result  <= ex_res;
            cc_out  <= ex_cc;
            illegal <= (op_q == sow_pkg::op_not_single);
        end
    end

    // completion strobes last exactly one cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done     <= 1'b0;
            write_en <= 1'b0;
        end else begin
            done     <= finish;
            write_en <= finish && ex_wr;
        end
    end

    //======================================================================
    // checks
    logic [9:0] lat;
    logic [7:0] dcy_q;

    // elapsed cycles since the request, for the timing check
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lat   <= 10'h000;
            dcy_q <= 8'h00;
        end else if (take) begin
            lat   <= 10'h000;
            dcy_q <= dst_cycles;
        end else if (state == sow_pkg::st_run) begin
            lat   <= 10'(lat + 10'h001);
        end
    end

    // all checks run on the one clock and sleep while reset is low
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // clear leaves a zero word with only the zero flag up
    a_zero_dest_out: assert property (
        done && op_q == sow_pkg::op_zero_dest |->
        result == sow_pkg::ZERO_W && cc_out == 4'h4)
        else $error("clear result or flags wrong");

    // increment keeps carry
    a_add_one_out: assert property (
        done && op_q == sow_pkg::op_add_one |->
        result == 16'(opd_q + sow_pkg::ONE_W) && cc_out.c == cin_q.c
        && cc_out.v == (opd_q == sow_pkg::MAX_POS))
        else $error("increment result or flags wrong");

    // decrement keeps carry
    a_sub_one_out: assert property (
        done && op_q == sow_pkg::op_sub_one |->
        result == 16'(opd_q - sow_pkg::ONE_W) && cc_out.c == cin_q.c
        && cc_out.v == (opd_q == sow_pkg::MSB_ONLY)
        && cc_out.n == result[15])
        else $error("decrement result or flags wrong");

    // negate: operand plus result wraps to zero
    a_negate_out: assert property (
        done && op_q == sow_pkg::op_twos_negate |->
        16'(result + opd_q) == sow_pkg::ZERO_W
        && cc_out.c == (result != sow_pkg::ZERO_W)
        && cc_out.v == (result == sow_pkg::MSB_ONLY))
        else $error("negate result or flags wrong");

    // test never asks for a write
    a_check_hold: assert property (
        done && op_q == sow_pkg::op_check_value |->
        !write_en && result == opd_q && !cc_out.c && !cc_out.v
        && cc_out.z == (opd_q == sow_pkg::ZERO_W))
        else $error("test wrote or set wrong flags");

    // complement always sets carry
    a_invert_out: assert property (
        done && op_q == sow_pkg::op_invert_bits |->
        (result ^ opd_q) == sow_pkg::ALL_ONES && cc_out.c && !cc_out.v)
        else $error("complement result or flags wrong");

    // add carry: C and V set only at the wrap points
    a_carry_add: assert property (
        done && op_q == sow_pkg::op_add_carry_in |->
        cc_out.c == (opd_q == sow_pkg::ALL_ONES && cin_q.c)
        && cc_out.v == (opd_q == sow_pkg::MAX_POS && cin_q.c))
        else $error("add carry flags wrong");

    // subtract carry: carry clear only on zero with carry in
    a_carry_sub: assert property (
        done && op_q == sow_pkg::op_sub_carry_in |->
        cc_out.c == !(result == sow_pkg::ZERO_W && cin_q.c)
        && cc_out.v == (result == sow_pkg::MSB_ONLY))
        else $error("subtract carry flags wrong");

    // bit 0 leaves into carry, carry enters bit 15
    a_rotate_right: assert property (
        done && op_q == sow_pkg::op_rotate_right |->
        cc_out.c == opd_q[0] && result[15] == cin_q.c
        && result[14:0] == opd_q[15:1])
        else $error("rotate right wrong");

    // bit 15 leaves into carry, carry enters bit 0
    a_rotate_left: assert property (
        done && op_q == sow_pkg::op_rotate_left |->
        cc_out.c == opd_q[15] && result[0] == cin_q.c
        && result[15:1] == opd_q[14:0])
        else $error("rotate left wrong");

    // overflow taken from the settled sign and carry
    a_rotate_ovf: assert property (
        done && (op_q == sow_pkg::op_rotate_right
        || op_q == sow_pkg::op_rotate_left) |->
        cc_out.v == (result[15] ^ cc_out.c))
        else $error("rotate overflow wrong");

    // swap flags follow the new low byte
    a_swap_out: assert property (
        done && op_q == sow_pkg::op_byte_exchange |->
        result == {opd_q[7:0], opd_q[15:8]} && cc_out.n == opd_q[15]
        && cc_out.z == (opd_q[15:8] == sow_pkg::ZERO_B) && !cc_out.c && !cc_out.v)
        else $error("byte swap wrong");

    // stray decode agrees with the operation code list; destination field split off
    a_field_split: assert property (
        take |=>
        dst_spec == $past(instr[5:0]) && busy
        && (op_q == sow_pkg::op_not_single) == $past(instr[15:6] != 10'h028
        && instr[15:6] != 10'h029 && (instr[15:6] < 10'h02A || instr[15:6] > 10'h031)
        && instr[15:6] != 10'h003))
        else $error("instruction fields split wrong");

    // a stray word completes two edges after it is taken
    a_stray_quick: assert property (
        take && next_op == sow_pkg::op_not_single |=>
        ##1 done && illegal && !write_en)
        else $error("stray word not finished at once");

    // lat counts the edges after the taking edge
    a_exec_time: assert property (
        $rose(done) && !illegal |->
        lat == 10'(10'(sow_pkg::BASIC_CYC) + {2'b00, dcy_q}))
        else $error("execution time wrong");

    // a taken request shows busy before any completion
    a_busy_take: assert property (
        take |=>
        busy && !done)
        else $error("busy missing after take");

    // result and flags only move on the completing edge
    a_result_hold: assert property (
        !done |->
        $stable(result) && $stable(cc_out))
        else $error("result or flags moved without completion");

    // a write request only ever rides on a legal completion
    a_write_strobe: assert property (
        write_en |->
        done && !illegal)
        else $error("write strobe outside completion");

    // back to back is legal, so busy may rise right after done
    a_done_pulse: assert property (
        done |=>
        !done && busy == $past(take))
        else $error("completion not a single pulse");

    // main scenarios: rotate, borrow chain, stray word, back to back
    c_rot_left: cover property (done && op_q == sow_pkg::op_rotate_left);
    c_sub_carry: cover property (done && op_q == sow_pkg::op_sub_carry_in && cin_q.c);
    c_not_ours: cover property (done && illegal);
    c_back_back: cover property (done ##0 take);

endmodule : sow_alu

// ==== testbench/sow_seq_model.sv ====
`timescale 1ns/100ps
//==========================================================================
// sequencer side: hands one request over, then waits for its completion
module sow_seq_model (
    input  wire logic        clk,        // system clock
    input  wire logic        rst_n,      // reset, aborts a wait
    input  wire logic        busy,       // datapath busy
    input  wire logic        done,       // completion pulse
    output logic             start,      // request strobe
    output logic [15:0]      instr,      // instruction word
    output logic [15:0]      operand,    // destination operand
    output sow_pkg::sow_cc_t cc_in,      // flags before the operation
    output logic [7:0]       dst_cycles  // destination address time
);
    initial begin
        start      = 1'b0;
        instr      = 16'h0000;
        operand    = 16'h0000;
        cc_in      = 4'h0;
        dst_cycles = 8'h00;
    end

    //======================================================================
    // called at a falling edge; n counts falling edges up to done
    // after the take the request fields show their inverse (instr turns into a clear word under pest), so a late
    // sample is caught; pest keeps start high for three more falling edges while busy, to be refused
    task automatic issue(input logic [15:0] i, input logic [15:0] o,
                         input sow_pkg::sow_cc_t c, input logic [7:0] d,
                         input bit pest, output int n, output logic b1);
        n = 0;
        while (busy !== 1'b0 && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (n >= 400) return;
        start      = 1'b1;
        instr      = i;
        operand    = o;
        cc_in      = c;
        dst_cycles = d;
        n          = 0;
        b1         = 1'b0;
        do begin
            @(negedge clk);
            n++;
            if (n == 1) begin
                b1         = busy;
                instr      = pest ? {sow_pkg::OPC_ZERO, 6'h00} : ~i;
                operand    = ~o;
                cc_in      = ~c;
                dst_cycles = ~d;
            end
            if (n == 1 || n == 4) start = pest && n < 4;
        end while (done !== 1'b1 && n < 400 && rst_n !== 1'b0);
    endtask : issue
endmodule : sow_seq_model

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
//==========================================================================
// self-checking bench for the single-operand word datapath
module tb;
    logic             clk;        // system clock
    logic             rst_n;      // synchronous reset
    logic             start;      // request strobe
    logic [15:0]      instr;      // instruction word
    logic [15:0]      operand;    // destination operand
    sow_pkg::sow_cc_t cc_in;      // flags before
    logic [7:0]       dst_cycles; // address time
    logic             busy;       // busy
    logic             done;       // completion
    logic [15:0]      result;     // result word
    sow_pkg::sow_cc_t cc_out;     // flags after
    logic             write_en;   // write back
    logic             illegal;    // not a single-operand word
    logic [5:0]       dst_spec;   // destination specifier
    int               errors;     // mismatches
    int               checked;    // comparisons
    logic [9:0]  ops [11] = '{sow_pkg::OPC_ZERO, sow_pkg::OPC_INVERT, sow_pkg::OPC_ADD1,
        sow_pkg::OPC_SUB1, sow_pkg::OPC_NEGATE, sow_pkg::OPC_ADDC, sow_pkg::OPC_SUBC,
        sow_pkg::OPC_CHECK, sow_pkg::OPC_ROT_R, sow_pkg::OPC_ROT_L, sow_pkg::OPC_SWAP};
    logic [15:0] vals [6] = '{16'h0000, 16'h0001, 16'h7FFF, 16'h8000, 16'hFFFF, 16'h00FF};

    sow_alu u_sow_alu (.clk(clk), .rst_n(rst_n), .start(start), .instr(instr),
        .operand(operand), .cc_in(cc_in), .dst_cycles(dst_cycles), .busy(busy),
        .done(done), .result(result), .cc_out(cc_out), .write_en(write_en),
        .illegal(illegal), .dst_spec(dst_spec));
    sow_seq_model u_sow_seq_model (.clk(clk), .rst_n(rst_n), .busy(busy), .done(done),
        .start(start), .instr(instr), .operand(operand), .cc_in(cc_in),
        .dst_cycles(dst_cycles));

    //======================================================================
    // clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic bad(input string m);
        $display("unexpected %0t %s", $time, m);
        errors++;
    endtask : bad

    task automatic conclude();
        if (errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    //======================================================================
    // expected {illegal, write, flags, result}, worked out independently
    function automatic logic [21:0] expect_op(input logic [9:0] opc, input logic [15:0] o,
                                              input sow_pkg::sow_cc_t ci);
        logic [15:0]      r;
        sow_pkg::sow_cc_t f;
        logic             w;
        w = 1'b1;
        f = ci;
        case (opc)
            sow_pkg::OPC_ZERO:   begin r = 16'h0000; f.c = 1'b0; f.v = 1'b0; end
            sow_pkg::OPC_ADD1:   begin r = o + 16'h0001; f.v = o == 16'h7FFF; end
            sow_pkg::OPC_SUB1:   begin r = o - 16'h0001; f.v = o == 16'h8000; end
            sow_pkg::OPC_NEGATE: begin r = 16'h0000 - o; f.c = r != 16'h0000; f.v = r == 16'h8000; end
            sow_pkg::OPC_CHECK:  begin r = o; w = 1'b0; f.c = 1'b0; f.v = 1'b0; end
            sow_pkg::OPC_INVERT: begin r = ~o; f.c = 1'b1; f.v = 1'b0; end
            sow_pkg::OPC_ADDC:   begin r = o + {15'h0000, ci.c};
                f.c = o == 16'hFFFF && ci.c; f.v = o == 16'h7FFF && ci.c; end
            sow_pkg::OPC_SUBC:   begin r = o - {15'h0000, ci.c};
                f.c = !(r == 16'h0000 && ci.c); f.v = r == 16'h8000; end
            sow_pkg::OPC_ROT_R:  begin r = {ci.c, o[15:1]}; f.c = o[0]; end
            sow_pkg::OPC_ROT_L:  begin r = {o[14:0], ci.c}; f.c = o[15]; end
            sow_pkg::OPC_SWAP:   begin r = {o[7:0], o[15:8]}; f.c = 1'b0; f.v = 1'b0; end
            default:             return {2'b10, ci, o};
        endcase
        f.n = (opc == sow_pkg::OPC_SWAP) ? r[7] : r[15];
        f.z = (opc == sow_pkg::OPC_SWAP) ? r[7:0] == 8'h00 : r == 16'h0000;
        if (opc == sow_pkg::OPC_ROT_R || opc == sow_pkg::OPC_ROT_L) f.v = f.n ^ f.c;
        return {1'b0, w, f, r};
    endfunction : expect_op

    //======================================================================
    // one request through the sequencer model, then every output compared
    task automatic run(input logic [9:0] opc, input logic [15:0] o, input logic [3:0] c,
                       input logic [7:0] d, input bit pest);
        logic [21:0] e;
        logic [5:0]  ds;
        int          n;
        logic        b1;
        ds = 6'($urandom);
        e  = expect_op(opc, o, c);
        u_sow_seq_model.issue({opc, ds}, o, c, d, pest, n, b1);
        if (n >= 400) begin
            bad("no completion");
            conclude();
        end else begin
            checked += 7;
            if (b1 !== 1'b1) bad("busy low after take");
            if (n != (e[21] ? 2 : 116 + int'(d))) bad("latency");
            if (result !== e[15:0]) bad("result");
            if (cc_out !== e[19:16]) bad("flags");
            if (write_en !== e[20]) bad("write enable");
            if (illegal !== e[21]) bad("illegal flag");
            if (dst_spec !== ds) bad("destination field");
        end
    endtask : run

    task automatic chk_reset();
        checked++;
        if ({busy, done, write_en, illegal, result, cc_out, dst_spec} !== 30'h0)
            bad("reset state");
    endtask : chk_reset

    //======================================================================
    // main sequence: reset, reset in mid-run, corners, then random traffic
    initial begin
        int   n;
        logic b1;
        errors  = 0;
        checked = 0;
        rst_n   = 1'b0;
        void'($urandom(32'h9E2CCECA));
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        chk_reset();
        fork
            u_sow_seq_model.issue({sow_pkg::OPC_INVERT, 6'h15}, 16'h1234, 4'h0, 8'h00, 1'b0, n, b1);
            begin
                repeat (5) @(negedge clk);
                rst_n = 1'b0;
                repeat (2) @(negedge clk);
                rst_n = 1'b1;
            end
        join
        chk_reset();
        foreach (ops[i])
            foreach (vals[j])
                for (int c = 0; c < 2; c++)
                    run(ops[i], vals[j], {3'($urandom), 1'(c)}, 8'h00, j == 0);
        for (int k = 0; k < 60; k++)
            run(($urandom % 4 == 0) ? 10'($urandom) : ops[$urandom % 11], 16'($urandom),
                4'($urandom), (k == 0) ? 8'hFF : 8'($urandom % 16), 1'b0);
        conclude();
    end
endmodule : tb
